// ### hdl/iops_pkg.sv
package iops_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] IOPS_CTRL_OFF   = 12'h000;
  localparam logic [11:0] IOPS_STATUS_OFF = 12'h004;
  localparam logic [11:0] IOPS_LOAD_OFF   = 12'h008;

  // Control fields
  localparam int IOPS_CTRL_TERM_LSB = 0;
  localparam int IOPS_CTRL_INV_BIT  = 2;
  localparam int IOPS_CTRL_UPU_BIT  = 3;
  localparam logic [3:0] IOPS_CTRL_RESET = 4'h0;
  localparam logic [3:0] IOPS_CTRL_MASK  = 4'hf;

  // Synchroniser reset: select strap idles high, supplies low
  localparam logic [6:0] IOPS_SYNC_RESET = 7'h08;

  // Load register: writing this bit ends configuration load
  localparam int IOPS_LOAD_DONE_BIT = 0;

  // Status fields
  localparam int IOPS_STAT_PHASE_LSB = 0;
  localparam int IOPS_STAT_MODE_LSB  = 4;
  localparam int IOPS_STAT_INITN_BIT = 7;
  localparam int IOPS_STAT_PSEL_BIT  = 8;
  localparam int IOPS_STAT_PWR_BIT   = 9;

  // Unused pin termination encodings
  localparam logic [1:0] IOPS_TERM_PULLDOWN = 2'h0;
  localparam logic [1:0] IOPS_TERM_PULLUP   = 2'h1;
  localparam logic [1:0] IOPS_TERM_FLOAT    = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [7:0] IOPS_MEMINIT_CYCLES = 8'h40;
  localparam logic [3:0] IOPS_STARTUP_DIV    = 4'h8;

  typedef enum logic [2:0] {
    IOPS_PH_POR     = 3'b000,
    IOPS_PH_MEMINIT = 3'b001,
    IOPS_PH_MODE    = 3'b010,
    IOPS_PH_LOAD    = 3'b011,
    IOPS_PH_SR_REL  = 3'b100,
    IOPS_PH_TS_REL  = 3'b101,
    IOPS_PH_WE_REL  = 3'b110,
    IOPS_PH_USER    = 3'b111
  } iops_phase_e;

endpackage

// ### hdl/iops_sequencer.sv
`timescale 1ns/10ps
module iops_sequencer
  import iops_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        supply_core_ok,
  input  wire logic        supply_aux_ok,
  input  wire logic        supply_bank2_ok,
  input  wire logic        config_pullup_select_n,
  input  wire logic        cfg_mode_sel_0,
  input  wire logic        cfg_mode_sel_1,
  input  wire logic        cfg_mode_sel_2,
  output logic             init_done_n,
  output logic [2:0]       cfg_mode,
  output logic             global_set_reset,
  output logic             global_tristate,
  output logic             global_write_enable,
  output logic             io_reg_init_level,
  output logic             cfg_pullup_en,
  output logic             user_pullup_en,
  output logic             unused_pullup_en,
  output logic             unused_pulldown_en,
  output logic             pullup_select_gpio
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
    reg_hit = (addr == off);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [6:0]  sync1_q, sync1_d;
  logic [6:0]  sync2_q, sync2_d;
  iops_phase_e phase_q, phase_d;
  logic [7:0]  init_cnt_q, init_cnt_d;
  logic [3:0]  div_cnt_q, div_cnt_d;
  logic        tick_q, tick_d;
  logic [3:0]  ctrl_q, ctrl_d;
  logic        load_done_q, load_done_d;
  logic [2:0]  mode_q, mode_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pslverr_q, pslverr_d;
  logic        pready_q, pready_d;
  logic        init_n_q, init_n_d;
  logic        gsr_q, gsr_d;
  logic        gts_q, gts_d;
  logic        gwe_q, gwe_d;
  logic        level_q, level_d;
  logic        cpu_q, cpu_d;
  logic        upu_q, upu_d;
  logic        unpu_q, unpu_d;
  logic        unpd_q, unpd_d;
  logic        gpio_q, gpio_d;

  logic        pwr_ok;
  logic        psel_n_s;
  logic        acc;
  logic        wr_ctrl;
  logic        wr_load;
  logic        mapped;
  logic        user_mode;
  logic [1:0]  term;

  assign pwr_ok    = &sync2_q[2:0];
  assign psel_n_s  = sync2_q[3];
  assign acc       = psel && penable && pready_q;
  assign mapped    = reg_hit(paddr, IOPS_CTRL_OFF) || reg_hit(paddr, IOPS_STATUS_OFF)
                     || reg_hit(paddr, IOPS_LOAD_OFF);
  assign wr_ctrl   = acc && pwrite && reg_hit(paddr, IOPS_CTRL_OFF);
  assign wr_load   = acc && pwrite && reg_hit(paddr, IOPS_LOAD_OFF);
  assign user_mode = (phase_q == IOPS_PH_USER);
  assign term      = ctrl_q[IOPS_CTRL_TERM_LSB +: 2];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    sync1_d = {cfg_mode_sel_2, cfg_mode_sel_1, cfg_mode_sel_0, config_pullup_select_n,
               supply_bank2_ok, supply_aux_ok, supply_core_ok};
    sync2_d = sync1_q;
    phase_d = phase_q;
    init_cnt_d = init_cnt_q;
    mode_d = mode_q;
    load_done_d = load_done_q;
    ctrl_d = ctrl_q;

    // Start-up clock enable
    if (div_cnt_q == IOPS_STARTUP_DIV - 4'h1)
    begin
      div_cnt_d = 4'h0;
      tick_d = 1'b1;
    end
    else
    begin
      div_cnt_d = div_cnt_q + 4'h1;
      tick_d = 1'b0;
    end

    if (wr_ctrl)
    begin
      ctrl_d = pwdata[3:0] & IOPS_CTRL_MASK;
    end
    if (wr_load && pwdata[IOPS_LOAD_DONE_BIT] && phase_q == IOPS_PH_LOAD)
    begin
      load_done_d = 1'b1;
    end

    case (phase_q)
      IOPS_PH_POR:
      begin
        init_cnt_d = 8'h00;
        load_done_d = 1'b0;
        if (pwr_ok)
        begin
          phase_d = IOPS_PH_MEMINIT;
        end
      end
      IOPS_PH_MEMINIT:
      begin
        init_cnt_d = init_cnt_q + 8'h01;
        if (init_cnt_q == IOPS_MEMINIT_CYCLES - 8'h01)
        begin
          phase_d = IOPS_PH_MODE;
        end
      end
      IOPS_PH_MODE:
      begin
        mode_d = sync2_q[6:4];
        phase_d = IOPS_PH_LOAD;
      end
      IOPS_PH_LOAD:
      begin
        if (load_done_q)
        begin
          phase_d = IOPS_PH_SR_REL;
        end
      end
      IOPS_PH_SR_REL:
      begin
        if (tick_q)
        begin
          phase_d = IOPS_PH_TS_REL;
        end
      end
      IOPS_PH_TS_REL:
      begin
        if (tick_q)
        begin
          phase_d = IOPS_PH_WE_REL;
        end
      end
      IOPS_PH_WE_REL:
      begin
        phase_d = IOPS_PH_USER;
      end
      IOPS_PH_USER:
      begin
        phase_d = IOPS_PH_USER;
      end
      default:
      begin
        phase_d = IOPS_PH_POR;
      end
    endcase
    if (!pwr_ok)
    begin
      phase_d = IOPS_PH_POR;
    end

    // Global nets and pad controls
    init_n_d = (phase_q != IOPS_PH_POR) && (phase_q != IOPS_PH_MEMINIT);
    gsr_d    = (phase_q <= IOPS_PH_LOAD);
    gts_d    = (phase_q <= IOPS_PH_SR_REL);
    gwe_d    = (phase_q >= IOPS_PH_WE_REL);
    level_d  = gsr_d ? 1'b0 : ctrl_q[IOPS_CTRL_INV_BIT];
    cpu_d    = gts_d && !psel_n_s;
    upu_d    = user_mode && ctrl_q[IOPS_CTRL_UPU_BIT];
    unpu_d   = !gts_d && (term == IOPS_TERM_PULLUP);
    unpd_d   = !gts_d && (term != IOPS_TERM_PULLUP) && (term != IOPS_TERM_FLOAT);
    gpio_d   = user_mode;

    // APB answer, zero wait states
    pready_d  = 1'b1;
    prdata_d  = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (psel && !penable)
    begin
      pslverr_d = !mapped;
      if (!pwrite && reg_hit(paddr, IOPS_CTRL_OFF))
      begin
        prdata_d[3:0] = ctrl_q;
      end
      if (!pwrite && reg_hit(paddr, IOPS_STATUS_OFF))
      begin
        prdata_d[IOPS_STAT_PHASE_LSB +: 3] = phase_q;
        prdata_d[IOPS_STAT_MODE_LSB +: 3]  = mode_q;
        prdata_d[IOPS_STAT_INITN_BIT]      = init_n_q;
        prdata_d[IOPS_STAT_PSEL_BIT]       = psel_n_s;
        prdata_d[IOPS_STAT_PWR_BIT]        = pwr_ok;
      end
    end
    else if (psel && penable)
    begin
      prdata_d  = prdata_q;
      pslverr_d = pslverr_q;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q     <= IOPS_SYNC_RESET;
      sync2_q     <= IOPS_SYNC_RESET;
      phase_q     <= IOPS_PH_POR;
      init_cnt_q  <= 8'h00;
      div_cnt_q   <= 4'h0;
      tick_q      <= 1'b0;
      ctrl_q      <= IOPS_CTRL_RESET;
      load_done_q <= 1'b0;
      mode_q      <= 3'h0;
      prdata_q    <= 32'h0000_0000;
      pslverr_q   <= 1'b0;
      pready_q    <= 1'b0;
      init_n_q    <= 1'b0;
      gsr_q       <= 1'b1;
      gts_q       <= 1'b1;
      gwe_q       <= 1'b0;
      level_q     <= 1'b0;
      cpu_q       <= 1'b0;
      upu_q       <= 1'b0;
      unpu_q      <= 1'b0;
      unpd_q      <= 1'b0;
      gpio_q      <= 1'b0;
    end
    else
    begin
      sync1_q     <= sync1_d;
      sync2_q     <= sync2_d;
      phase_q     <= phase_d;
      init_cnt_q  <= init_cnt_d;
      div_cnt_q   <= div_cnt_d;
      tick_q      <= tick_d;
      ctrl_q      <= ctrl_d;
      load_done_q <= load_done_d;
      mode_q      <= mode_d;
      prdata_q    <= prdata_d;
      pslverr_q   <= pslverr_d;
      pready_q    <= pready_d;
      init_n_q    <= init_n_d;
      gsr_q       <= gsr_d;
      gts_q       <= gts_d;
      gwe_q       <= gwe_d;
      level_q     <= level_d;
      cpu_q       <= cpu_d;
      upu_q       <= upu_d;
      unpu_q      <= unpu_d;
      unpd_q      <= unpd_d;
      gpio_q      <= gpio_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign init_done_n         = init_n_q;
  assign cfg_mode            = mode_q;
  assign global_set_reset    = gsr_q;
  assign global_tristate     = gts_q;
  assign global_write_enable = gwe_q;
  assign io_reg_init_level   = level_q;
  assign cfg_pullup_en       = cpu_q;
  assign user_pullup_en      = upu_q;
  assign unused_pullup_en    = unpu_q;
  assign unused_pulldown_en  = unpd_q;
  assign pullup_select_gpio  = gpio_q;

endmodule // iops_sequencer

// ### tb/iops_board_straps.sv
`timescale 1ns/10ps
module iops_board_straps
(
  input  wire logic       drive_sel,
  input  wire logic       sel_val,
  input  wire logic [2:0] mode_val,
  output logic            config_pullup_select_n,
  output logic            cfg_mode_sel_0,
  output logic            cfg_mode_sel_1,
  output logic            cfg_mode_sel_2
);
  // Weak pull-up when board leaves it open
  assign config_pullup_select_n = drive_sel ? sel_val : 1'b1;
  assign {cfg_mode_sel_2, cfg_mode_sel_1, cfg_mode_sel_0} = mode_val;
endmodule // iops_board_straps

// ### tb/iops_sequencer_asserts.sv
`timescale 1ns/10ps
module iops_sequencer_asserts
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic supply_core_ok,
  input wire logic init_done_n,
  input wire logic [2:0] cfg_mode,
  input wire logic global_set_reset,
  input wire logic global_tristate,
  input wire logic global_write_enable,
  input wire logic io_reg_init_level,
  input wire logic cfg_pullup_en,
  input wire logic user_pullup_en,
  input wire logic unused_pullup_en,
  input wire logic unused_pulldown_en,
  input wire logic pullup_select_gpio
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_hz; global_set_reset |-> global_tristate; endproperty
  a_hz: assert property (p_hz) else $error("driver on in config");
  property p_cpu; cfg_pullup_en |-> global_tristate && !pullup_select_gpio; endproperty
  a_cpu: assert property (p_cpu) else $error("config pull-up late");
  property p_init; !init_done_n |-> global_set_reset && !global_write_enable; endproperty
  a_init: assert property (p_init) else $error("set/reset off in init");
  property p_mode;
    global_write_enable && $past(global_write_enable) |-> $stable(cfg_mode);
  endproperty
  a_mode: assert property (p_mode) else $error("mode moved");
  property p_lvl; global_set_reset |-> !io_reg_init_level; endproperty
  a_lvl: assert property (p_lvl) else $error("io level high");
  property p_ts; $fell(global_tristate) |-> !global_set_reset && !global_write_enable; endproperty
  a_ts: assert property (p_ts) else $error("three-state order");
  property p_we; $fell(global_tristate) |-> ##8 $rose(global_write_enable); endproperty
  a_we: assert property (p_we) else $error("write enable late");
  property p_we2; $rose(global_write_enable) |-> !$past(global_tristate); endproperty
  a_we2: assert property (p_we2) else $error("write enable early");
  property p_un;
    unused_pullup_en || unused_pulldown_en |-> !global_tristate
      && !(unused_pullup_en && unused_pulldown_en);
  endproperty
  a_un: assert property (p_un) else $error("unused termination");
  property p_pwr; !supply_core_ok |-> ##[1:6] global_tristate && global_set_reset; endproperty
  a_pwr: assert property (p_pwr) else $error("supply loss ignored");
  property p_upu; user_pullup_en |-> pullup_select_gpio && !global_tristate; endproperty
  a_upu: assert property (p_upu) else $error("user pull-up early");
  c_we: cover property ($rose(global_write_enable));
  c_ts: cover property ($fell(global_tristate));
  c_pu: cover property (cfg_pullup_en);
endmodule // iops_sequencer_asserts

// ### tb/tb_iops_sequencer.sv
`timescale 1ns/10ps
module tb_iops_sequencer;
  import iops_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rs = 32'h0000c677;
  logic        pready, pslverr, supply_core_ok = 0, supply_aux_ok = 0, supply_bank2_ok = 0;
  logic        config_pullup_select_n, cfg_mode_sel_0, cfg_mode_sel_1, cfg_mode_sel_2;
  logic        init_done_n, global_set_reset, global_tristate, global_write_enable;
  logic        io_reg_init_level, cfg_pullup_en, user_pullup_en, unused_pullup_en;
  logic        unused_pulldown_en, pullup_select_gpio, drv = 0;
  logic [2:0]  cfg_mode, mv = 3'h0;
  logic [64:0] exp_q[$];
  int          n_fail = 0, n_tests = 0;
  iops_sequencer i_iops_sequencer (
    .pclk                   (pclk),
    .presetn                (presetn),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .supply_core_ok         (supply_core_ok),
    .supply_aux_ok          (supply_aux_ok),
    .supply_bank2_ok        (supply_bank2_ok),
    .config_pullup_select_n (config_pullup_select_n),
    .cfg_mode_sel_0         (cfg_mode_sel_0),
    .cfg_mode_sel_1         (cfg_mode_sel_1),
    .cfg_mode_sel_2         (cfg_mode_sel_2),
    .init_done_n            (init_done_n),
    .cfg_mode               (cfg_mode),
    .global_set_reset       (global_set_reset),
    .global_tristate        (global_tristate),
    .global_write_enable    (global_write_enable),
    .io_reg_init_level      (io_reg_init_level),
    .cfg_pullup_en          (cfg_pullup_en),
    .user_pullup_en         (user_pullup_en),
    .unused_pullup_en       (unused_pullup_en),
    .unused_pulldown_en     (unused_pulldown_en),
    .pullup_select_gpio     (pullup_select_gpio)
  );
  iops_board_straps i_iops_board_straps (
    .drive_sel              (drv),
    .sel_val                (1'b0),
    .mode_val               (mv),
    .config_pullup_select_n (config_pullup_select_n),
    .cfg_mode_sel_0         (cfg_mode_sel_0),
    .cfg_mode_sel_1         (cfg_mode_sel_1),
    .cfg_mode_sel_2         (cfg_mode_sel_2)
  );
  always #2 pclk = ~pclk;
  function logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task final_report;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [64:0] e);
    exp_q.push_back(e);
    apb(0, a, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // Read monitor
  // ----------------------------------------------------------------
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
    begin
      logic [64:0] e;
      e = exp_q.pop_front();
      chk("prdata", e[31:0], prdata & e[63:32]);
      chk("pslverr", {31'h0, e[64]}, {31'h0, pslverr});
    end
  initial
  begin
    #40000;
    n_fail++;
    final_report;
  end
  initial
  begin
    logic [3:0] c;
    logic [2:0] m;
    int t;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    for (int r = 0; r < 3; r++)
    begin
      m = 3'(rnd());
      c = 4'(rnd());
      mv <= m;
      drv <= r[0];
      repeat (4) @(posedge pclk);
      chk("gts", 1, global_tristate);
      chk("gsr", 1, global_set_reset);
      chk("init", 0, init_done_n);
      {supply_core_ok, supply_aux_ok, supply_bank2_ok} <= 3'h7;
      for (t = 0; t < 200 && init_done_n !== 1'b1; t++) @(posedge pclk);
      @(posedge pclk);
      mv <= ~m;
      chk("init", 1, init_done_n);
      chk("cpu", r[0], cfg_pullup_en);
      chk("gts", 1, global_tristate);
      chk("gsr", 1, global_set_reset);
      chk("mode", m, cfg_mode);
      rd(IOPS_STATUS_OFF, {1'b0, 32'h3ff, 22'h0, 1'b1, ~r[0], 1'b1, m, 4'h3});
      apb(1, IOPS_CTRL_OFF, {28'h0, c});
      rd(IOPS_CTRL_OFF, {1'b0, 32'hffffffff, 28'h0, c});
      rd(12'h010, {1'b1, 32'hffffffff, 32'h0});
      apb(1, IOPS_LOAD_OFF, 32'h1);
      for (t = 0; t < 100 && global_write_enable !== 1'b1; t++) @(posedge pclk);
      @(posedge pclk);
      chk("gwe", 1, global_write_enable);
      chk("gsr", 0, global_set_reset);
      chk("lvl", c[2], io_reg_init_level);
      chk("gts", 0, global_tristate);
      chk("cpu", 0, cfg_pullup_en);
      chk("gpio", 1, pullup_select_gpio);
      chk("upu", c[3], user_pullup_en);
      chk("upd", c[1:0] != IOPS_TERM_PULLUP && c[1:0] != IOPS_TERM_FLOAT,
          unused_pulldown_en);
      chk("uup", c[1:0] == IOPS_TERM_PULLUP, unused_pullup_en);
      chk("mode", m, cfg_mode);
      rd(IOPS_STATUS_OFF, {1'b0, 32'h3ff, 22'h0, 1'b1, ~r[0], 1'b1, m, 4'h7});
      {supply_core_ok, supply_aux_ok, supply_bank2_ok} <= 3'h7 ^ 3'(1 << r);
      repeat (6) @(posedge pclk);
      chk("gts", 1, global_tristate);
      chk("gwe", 0, global_write_enable);
      {supply_core_ok, supply_aux_ok, supply_bank2_ok} <= 3'h0;
    end
    final_report;
  end
endmodule // tb_iops_sequencer
bind iops_sequencer iops_sequencer_asserts i_iops_sequencer_asserts (
  .pclk                (pclk),
  .presetn             (presetn),
  .supply_core_ok      (supply_core_ok),
  .init_done_n         (init_done_n),
  .cfg_mode            (cfg_mode),
  .global_set_reset    (global_set_reset),
  .global_tristate     (global_tristate),
  .global_write_enable (global_write_enable),
  .io_reg_init_level   (io_reg_init_level),
  .cfg_pullup_en       (cfg_pullup_en),
  .user_pullup_en      (user_pullup_en),
  .unused_pullup_en    (unused_pullup_en),
  .unused_pulldown_en  (unused_pulldown_en),
  .pullup_select_gpio  (pullup_select_gpio)
);
